/* shared/adc_sel_pkg.sv */
// Purpose: shared constants and types for the converter input selection block
// Assumes: registers are 16 bits wide and sit at word indices on a plain port
// Notes: source kinds tell the analog front end what to close onto the channel
package adc_sel_pkg;

  // register indices on the plain register port
  localparam int unsigned REG_AW = 2;
  localparam logic [1:0] OFS_CH0 = 2'h0;
  localparam logic [1:0] OFS_SCAN_LOW = 2'h1;
  localparam logic [1:0] OFS_SCAN_HIGH = 2'h2;
  localparam logic [1:0] OFS_SCAN_STAT = 2'h3;

  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] CH0_RESET = 16'h0000;
  localparam logic [15:0] SCAN_RESET = 16'h0000;
  // bits 14 and 6 are unimplemented and read as zero
  localparam logic [15:0] CH0_WMASK = 16'hbfbf;

  // channel 0 select field layout, mux A half
  localparam int unsigned NEG_A_BIT = 7;
  localparam int unsigned POS_A_MSB = 5;
  localparam int unsigned POS_A_LSB = 0;
  localparam int unsigned POS_W = 6;

  // positive select codes
  localparam logic [5:0] CODE_OPEN = 6'h3f;
  localparam logic [5:0] CODE_TEMP = 6'h3e;
  localparam logic [5:0] CODE_LAST_PIN = 6'h31;
  localparam logic [5:0] CODE_UPPER_FIRST = 6'h20;
  localparam logic [5:0] CODE_OPAMP2 = 6'h00;
  localparam logic [5:0] CODE_OPAMP1 = 6'h03;
  localparam logic [5:0] CODE_OPAMP3 = 6'h06;
  localparam logic [5:0] CODE_OPAMP5 = 6'h19;

  // op amp numbers; routing enable bit is number minus one
  localparam int unsigned OA_COUNT = 5;
  localparam logic [2:0] OPAMP1_NUM = 3'h1;
  localparam logic [2:0] OPAMP2_NUM = 3'h2;
  localparam logic [2:0] OPAMP3_NUM = 3'h3;
  localparam logic [2:0] OPAMP5_NUM = 3'h5;

  // scan selection
  localparam int unsigned SCAN_N = 32;
  localparam int unsigned SCAN_W = 5;
  localparam logic [4:0] SCAN_OPAMP1_SLOT = 5'h18;
  localparam logic [4:0] SCAN_OPAMP2_SLOT = 5'h19;
  localparam logic [4:0] SCAN_OPAMP3_SLOT = 5'h1a;
  localparam int unsigned STAT_ACTIVE_BIT = 15;

  typedef enum logic [2:0] {
    SRC_PIN = 3'b000,
    SRC_OPAMP = 3'b001,
    SRC_TEMP = 3'b010,
    SRC_OPEN = 3'b011,
    SRC_LOWREF = 3'b100
  } src_t;

  typedef enum logic [0:0] {
    NEG_LOWREF = 1'b0,
    NEG_INPUT1 = 1'b1
  } neg_t;

endpackage

/* core/scan_stepper.sv */
// Purpose: finds the first selected scan input and the one after the current
// Assumes: sel is stable for the cycle in which the result is used
// Notes: pure logic; the caller holds the scan position register
module scan_stepper #(
  parameter int N = 32,
  parameter int W = 5
) (
  input wire logic [N-1:0] sel,
  input wire logic [W-1:0] cur,
  output logic [W-1:0] first_idx,
  output logic [W-1:0] next_idx,
  output logic any_sel
);

  logic [N-1:0] above;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_above
      assign above[g] = sel[g] && (g > int'(cur));
    end
  endgenerate

  // lowest set bit; scanning downward lets the last hit win
  function automatic logic [W-1:0] lowest(input logic [N-1:0] m);
    logic [W-1:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = W'(i);
      end
    end
    return r;
  endfunction

  assign first_idx = lowest(sel);
  // nothing selected above the current input: wrap to the lowest one
  assign next_idx = (|above) ? lowest(above) : first_idx;
  assign any_sel = |sel;

endmodule

/* core/adc_input_select.sv */
// Purpose: channel 0 mux A input routing and input scan selection for one converter
// Assumes: register port and all inputs are synchronous to REF_CLK (25 MHz)
// Notes: routing outputs follow the registers one edge after they change

// Notes on behaviour
// - negative select bit 7 high picks input 1, low picks the low reference
// - positive select code up to 49 connects the input with that number
// - code all ones leaves the positive input unconnected
// - code 111110 connects the charge-time unit temperature voltage on the first instance only
// - codes 50 through 61 are reserved; software avoids them, device leaves open
// - codes 0, 3, 6, 25 use op amps 2, 1, 3, 5 when routed
// - second instance has no inputs 32-63; software keeps the top bit zero
// - inputs 32 through 49 exist only in 10-bit mode
// - a set scan bit includes its input; a clear bit skips it
// - low scan register bit x controls input x for x 0 to 15
// - high scan register holds scan bits 16 to 31, bit 31 on top
// - scan bits 24, 25, 26 pick op amp 1, 2, 3 or inputs 3, 0, 6
// - all scan bits writable; absent inputs sample the low reference
// - channel 0 select bit 6 is unimplemented and reads as zero
module adc_input_select #(
  parameter bit SECOND_INST = 1'b0,
  parameter int PIN_COUNT = 50
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic [4:0] OPAMP_ROUTE_EN,
  input wire logic MODE_10BIT,
  input wire logic SCAN_RESTART,
  input wire logic SCAN_ADVANCE,
  output adc_sel_pkg::neg_t CH0_NEG_SRC,
  output adc_sel_pkg::src_t CH0_POS_SRC,
  output logic [5:0] CH0_POS_IDX,
  output logic [4:0] SCAN_POS,
  output logic SCAN_ACTIVE,
  output adc_sel_pkg::src_t SCAN_SRC,
  output logic [5:0] SCAN_SRC_IDX
);

  logic [15:0] ch0_q;
  logic [15:0] scan_low_q;
  logic [15:0] scan_high_q;
  logic [15:0] rdata_q;
  logic [4:0] scan_pos_q;
  logic scan_active_q;
  adc_sel_pkg::neg_t neg_src_q;
  adc_sel_pkg::src_t pos_src_q;
  logic [5:0] pos_idx_q;
  adc_sel_pkg::src_t scan_src_q;
  logic [5:0] scan_src_idx_q;
  // selection one edge back, so the checks judge a step against what it saw
  logic [31:0] sel_prev_q;

  // register decode
  wire wr_ch0 = WR && (ADDR == adc_sel_pkg::OFS_CH0);
  wire wr_scan_low = WR && (ADDR == adc_sel_pkg::OFS_SCAN_LOW);
  wire wr_scan_high = WR && (ADDR == adc_sel_pkg::OFS_SCAN_HIGH);
  wire [31:0] scan_sel = {scan_high_q, scan_low_q};
  wire [15:0] stat_word = {scan_active_q, 10'h000, scan_pos_q};
  wire [15:0] rd_word =
    (ADDR == adc_sel_pkg::OFS_CH0) ? (ch0_q & adc_sel_pkg::CH0_WMASK) :
    (ADDR == adc_sel_pkg::OFS_SCAN_LOW) ? scan_low_q :
    (ADDR == adc_sel_pkg::OFS_SCAN_HIGH) ? scan_high_q :
    stat_word;
  // idle read data stay zero so the return word can be or-ed with other slaves
  wire [15:0] rdata_d = RD ? rd_word : 16'h0000;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ch0_q <= adc_sel_pkg::CH0_RESET;
      scan_low_q <= adc_sel_pkg::SCAN_RESET;
      scan_high_q <= adc_sel_pkg::SCAN_RESET;
      rdata_q <= 16'h0000;
    end else begin
      if (wr_ch0) begin
        ch0_q <= WDATA & adc_sel_pkg::CH0_WMASK;
      end
      if (wr_scan_low) begin
        scan_low_q <= WDATA;
      end
      if (wr_scan_high) begin
        scan_high_q <= WDATA;
      end
      rdata_q <= rdata_d;
    end
  end

  // channel 0 mux A decode
  wire [5:0] pos_code = ch0_q[adc_sel_pkg::POS_A_MSB:adc_sel_pkg::POS_A_LSB];
  wire adc_sel_pkg::neg_t neg_src_d = adc_sel_pkg::neg_t'(ch0_q[adc_sel_pkg::NEG_A_BIT]);
  wire code_is_oa = (pos_code == adc_sel_pkg::CODE_OPAMP2) ||
    (pos_code == adc_sel_pkg::CODE_OPAMP1) ||
    (pos_code == adc_sel_pkg::CODE_OPAMP3) || (pos_code == adc_sel_pkg::CODE_OPAMP5);
  wire [2:0] code_oa_num =
    (pos_code == adc_sel_pkg::CODE_OPAMP2) ? adc_sel_pkg::OPAMP2_NUM :
    (pos_code == adc_sel_pkg::CODE_OPAMP1) ? adc_sel_pkg::OPAMP1_NUM :
    (pos_code == adc_sel_pkg::CODE_OPAMP3) ? adc_sel_pkg::OPAMP3_NUM :
    adc_sel_pkg::OPAMP5_NUM;
  wire [2:0] code_oa_bit = code_oa_num - 3'h1;
  wire code_oa_on = code_is_oa && OPAMP_ROUTE_EN[code_oa_bit];
  wire code_upper = pos_code >= adc_sel_pkg::CODE_UPPER_FIRST;
  // second instance keeps the stored top bit but never routes it
  wire code_inst_block = SECOND_INST && code_upper;
  wire code_12b_block = code_upper && (pos_code <= adc_sel_pkg::CODE_LAST_PIN) &&
    !MODE_10BIT;
  wire code_reserved = (pos_code > adc_sel_pkg::CODE_LAST_PIN) &&
    (pos_code < adc_sel_pkg::CODE_TEMP);
  wire code_open = code_inst_block || code_12b_block || code_reserved ||
    (pos_code == adc_sel_pkg::CODE_OPEN);
  wire adc_sel_pkg::src_t pos_src_d =
    code_open ? adc_sel_pkg::SRC_OPEN :
    (pos_code == adc_sel_pkg::CODE_TEMP) ? adc_sel_pkg::SRC_TEMP :
    code_oa_on ? adc_sel_pkg::SRC_OPAMP :
    adc_sel_pkg::SRC_PIN;
  wire [5:0] pos_idx_d =
    (pos_src_d == adc_sel_pkg::SRC_OPAMP) ? {3'h0, code_oa_num} :
    (pos_src_d == adc_sel_pkg::SRC_PIN) ? pos_code :
    6'h00;

  // scan stepping
  logic [4:0] step_first;
  logic [4:0] step_next;
  logic step_any;

  scan_stepper #(
    .N(adc_sel_pkg::SCAN_N),
    .W(adc_sel_pkg::SCAN_W)
  ) u_stepper (
    .sel(scan_sel),
    .cur(scan_pos_q),
    .first_idx(step_first),
    .next_idx(step_next),
    .any_sel(step_any)
  );

  // restart wins over advance so a fresh scan never begins mid-list
  wire [4:0] scan_pos_d =
    SCAN_RESTART ? step_first :
    SCAN_ADVANCE ? step_next :
    scan_pos_q;
  wire scan_oa_slot = (scan_pos_d >= adc_sel_pkg::SCAN_OPAMP1_SLOT) &&
    (scan_pos_d <= adc_sel_pkg::SCAN_OPAMP3_SLOT);
  wire [2:0] scan_oa_num =
    (scan_pos_d == adc_sel_pkg::SCAN_OPAMP1_SLOT) ? adc_sel_pkg::OPAMP1_NUM :
    (scan_pos_d == adc_sel_pkg::SCAN_OPAMP2_SLOT) ? adc_sel_pkg::OPAMP2_NUM :
    adc_sel_pkg::OPAMP3_NUM;
  wire [5:0] scan_oa_pin =
    (scan_pos_d == adc_sel_pkg::SCAN_OPAMP1_SLOT) ? adc_sel_pkg::CODE_OPAMP1 :
    (scan_pos_d == adc_sel_pkg::SCAN_OPAMP2_SLOT) ? adc_sel_pkg::CODE_OPAMP2 :
    adc_sel_pkg::CODE_OPAMP3;
  wire [2:0] scan_oa_bit = scan_oa_num - 3'h1;
  wire scan_oa_on = scan_oa_slot && OPAMP_ROUTE_EN[scan_oa_bit];
  wire scan_absent = !scan_oa_slot && (int'(scan_pos_d) >= PIN_COUNT);
  wire adc_sel_pkg::src_t scan_src_d =
    scan_absent ? adc_sel_pkg::SRC_LOWREF :
    scan_oa_on ? adc_sel_pkg::SRC_OPAMP :
    adc_sel_pkg::SRC_PIN;
  wire [5:0] scan_src_idx_d =
    scan_absent ? 6'h00 :
    scan_oa_on ? {3'h0, scan_oa_num} :
    scan_oa_slot ? scan_oa_pin :
    {1'b0, scan_pos_d};

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      scan_pos_q <= 5'h00;
      scan_active_q <= 1'b0;
      scan_src_q <= adc_sel_pkg::SRC_PIN;
      scan_src_idx_q <= 6'h00;
      sel_prev_q <= 32'h0000_0000;
    end else begin
      scan_pos_q <= scan_pos_d;
      scan_active_q <= step_any;
      scan_src_q <= scan_src_d;
      scan_src_idx_q <= scan_src_idx_d;
      sel_prev_q <= scan_sel;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      neg_src_q <= adc_sel_pkg::NEG_LOWREF;
      pos_src_q <= adc_sel_pkg::SRC_PIN;
      pos_idx_q <= 6'h00;
    end else begin
      neg_src_q <= neg_src_d;
      pos_src_q <= pos_src_d;
      pos_idx_q <= pos_idx_d;
    end
  end

  assign RDATA = rdata_q;
  assign CH0_NEG_SRC = neg_src_q;
  assign CH0_POS_SRC = pos_src_q;
  assign CH0_POS_IDX = pos_idx_q;
  assign SCAN_POS = scan_pos_q;
  assign SCAN_ACTIVE = scan_active_q;
  assign SCAN_SRC = scan_src_q;
  assign SCAN_SRC_IDX = scan_src_idx_q;

  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  sequence ch0_write_s;
    WR && (ADDR == adc_sel_pkg::OFS_CH0);
  endsequence

  sequence advance_s;
    SCAN_ADVANCE && !SCAN_RESTART && step_any;
  endsequence

  sequence restart_s;
    SCAN_RESTART && step_any;
  endsequence

  // helper for the checks: every scan bit below the current position
  wire [31:0] below_mask = (32'h0000_0001 << SCAN_POS) - 32'h0000_0001;

  neg_route_a: assert property (
    ch0_write_s |-> ##2 (CH0_NEG_SRC == $past(WDATA[adc_sel_pkg::NEG_A_BIT], 2)))
    else $error("negative input does not follow written select bit");

  pin_route_a: assert property (
    ($past(pos_code) < adc_sel_pkg::CODE_UPPER_FIRST) && !$past(code_oa_on)
    |-> (CH0_POS_SRC == adc_sel_pkg::SRC_PIN) && (CH0_POS_IDX == $past(pos_code)))
    else $error("low code does not route its pin");

  open_code_a: assert property (
    ($past(pos_code) == adc_sel_pkg::CODE_OPEN) |-> (CH0_POS_SRC == adc_sel_pkg::SRC_OPEN))
    else $error("all ones code not left open");

  temp_route_a: assert property (
    ($past(pos_code) == adc_sel_pkg::CODE_TEMP) && !SECOND_INST
    |-> (CH0_POS_SRC == adc_sel_pkg::SRC_TEMP))
    else $error("temperature code not routed");

  reserved_open_a: assert property (
    $past(code_reserved) |-> (CH0_POS_SRC == adc_sel_pkg::SRC_OPEN))
    else $error("reserved code connects a source");

  opamp_route_a: assert property (
    $past(code_oa_on)
    |-> (CH0_POS_SRC == adc_sel_pkg::SRC_OPAMP) && (CH0_POS_IDX == {3'h0, $past(code_oa_num)}))
    else $error("routed op amp not substituted");

  second_inst_a: assert property (
    SECOND_INST && $past(code_upper) |-> (CH0_POS_SRC == adc_sel_pkg::SRC_OPEN))
    else $error("upper input reached on second instance");

  mode_gate_a: assert property (
    $past(code_upper) && ($past(pos_code) <= adc_sel_pkg::CODE_LAST_PIN) && !$past(MODE_10BIT)
    |-> (CH0_POS_SRC == adc_sel_pkg::SRC_OPEN))
    else $error("upper input reached in 12-bit mode");

  scan_skip_a: assert property (
    advance_s |=> sel_prev_q[SCAN_POS])
    else $error("scan landed on a cleared input");

  low_write_a: assert property (
    WR && (ADDR == adc_sel_pkg::OFS_SCAN_LOW) |=> (scan_sel[15:0] == $past(WDATA)))
    else $error("low scan bits not written");

  high_write_a: assert property (
    WR && (ADDR == adc_sel_pkg::OFS_SCAN_HIGH) |=> (scan_sel[31:16] == $past(WDATA)))
    else $error("high scan bits not written");

  scan_opamp_a: assert property (
    (SCAN_POS == adc_sel_pkg::SCAN_OPAMP1_SLOT) && $past(OPAMP_ROUTE_EN[0])
    |-> (SCAN_SRC == adc_sel_pkg::SRC_OPAMP) && (SCAN_SRC_IDX == 6'h01))
    else $error("scan slot 24 ignores op amp 1");

  absent_lowref_a: assert property (
    (int'(SCAN_POS) >= PIN_COUNT) && (SCAN_POS > adc_sel_pkg::SCAN_OPAMP3_SLOT)
    |-> (SCAN_SRC == adc_sel_pkg::SRC_LOWREF))
    else $error("absent scan input not on low reference");

  bit6_zero_a: assert property (
    RD && (ADDR == adc_sel_pkg::OFS_CH0) |=> (RDATA[6] == 1'b0) && (RDATA[14] == 1'b0))
    else $error("unimplemented select bit reads nonzero");

  scan_order_a: assert property (
    advance_s |=> (SCAN_POS > $past(scan_pos_q)) || (SCAN_POS == $past(step_first)))
    else $error("scan neither stepped up nor wrapped to lowest");

  restart_first_a: assert property (
    restart_s
    |=> sel_prev_q[SCAN_POS] && ((sel_prev_q & below_mask) == 32'h0000_0000))
    else $error("restart did not land on the lowest selected input");

  scan_live_a: assert property (
    advance_s |=> SCAN_ACTIVE)
    else $error("scan reported idle while inputs are selected");

  scan_empty_a: assert property (
    (scan_sel == 32'h0000_0000) |=> !SCAN_ACTIVE)
    else $error("scan reported active with nothing selected");

  status_read_a: assert property (
    RD && (ADDR == adc_sel_pkg::OFS_SCAN_STAT)
    |=> (RDATA[4:0] == $past(SCAN_POS)) && (RDATA[15] == $past(SCAN_ACTIVE)) &&
    (RDATA[14:5] == 10'h000))
    else $error("status word does not show scan state");

endmodule

/* verif/adc_input_select_tb_top.sv */
// Purpose: self-checking bench for the channel 0 routing and scan selection block
// Assumes: register port reads answer one cycle after the strobe edge
// Notes: PIN_COUNT is cut to 20 so that absent scan inputs show up early
module adc_input_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [4:0] route_en = 5'h00;
  logic mode10 = 1'b1;
  logic restart = 1'b0;
  logic advance = 1'b0;
  adc_sel_pkg::neg_t neg_src;
  adc_sel_pkg::src_t pos_src;
  adc_sel_pkg::src_t pos_src2;
  adc_sel_pkg::src_t scan_src;
  logic [5:0] pos_idx;
  logic [5:0] scan_idx;
  logic [4:0] scan_pos;
  logic scan_active;
  int num_errors = 0;
  int checks = 0;

  always #20 ref_clk = ~ref_clk;

  adc_input_select #(.SECOND_INST(1'b0), .PIN_COUNT(20)) DUT (
    .REF_CLK(ref_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .OPAMP_ROUTE_EN(route_en), .MODE_10BIT(mode10),
    .SCAN_RESTART(restart), .SCAN_ADVANCE(advance), .CH0_NEG_SRC(neg_src),
    .CH0_POS_SRC(pos_src), .CH0_POS_IDX(pos_idx), .SCAN_POS(scan_pos),
    .SCAN_ACTIVE(scan_active), .SCAN_SRC(scan_src), .SCAN_SRC_IDX(scan_idx)
  );

  // second converter instance shares the bus; only its routing is watched
  adc_input_select #(.SECOND_INST(1'b1), .PIN_COUNT(50)) DUT2 (
    .REF_CLK(ref_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(), .OPAMP_ROUTE_EN(route_en), .MODE_10BIT(mode10),
    .SCAN_RESTART(restart), .SCAN_ADVANCE(advance), .CH0_NEG_SRC(),
    .CH0_POS_SRC(pos_src2), .CH0_POS_IDX(), .SCAN_POS(),
    .SCAN_ACTIVE(), .SCAN_SRC(), .SCAN_SRC_IDX()
  );

  task automatic end_sim();
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp, input string name);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(name, rdata, exp);
  endtask

  // negative select follows the code's low bit so both levels are exercised
  task automatic route(input logic [5:0] code, input logic [4:0] en, input logic mode,
                       input adc_sel_pkg::src_t src, input logic [5:0] idx);
    @(posedge ref_clk);
    route_en <= en;
    mode10 <= mode;
    wr_reg(adc_sel_pkg::OFS_CH0, {8'h00, code[0], 1'b0, code});
    repeat (2) @(posedge ref_clk);
    #1;
    chk("ch0_pos_src", 16'(pos_src), 16'(src));
    chk("ch0_pos_idx", {10'h000, pos_idx}, {10'h000, idx});
    chk("ch0_neg_src", {15'h0000, neg_src}, {15'h0000, code[0]});
  endtask

  task automatic step(input logic rs, input logic [4:0] pos,
                      input adc_sel_pkg::src_t src, input logic [5:0] idx);
    @(posedge ref_clk);
    if (rs) begin
      restart <= 1'b1;
    end else begin
      advance <= 1'b1;
    end
    @(posedge ref_clk);
    restart <= 1'b0;
    advance <= 1'b0;
    #1;
    chk("scan_pos", {11'h000, scan_pos}, {11'h000, pos});
    chk("scan_src", 16'(scan_src), 16'(src));
    chk("scan_src_idx", {10'h000, scan_idx}, {10'h000, idx});
  endtask

  initial begin
    repeat (4000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    rd_chk(2'h0, 16'h0000, "ch0_reset");
    rd_chk(2'h1, 16'h0000, "scan_low_reset");
    rd_chk(2'h2, 16'h0000, "scan_high_reset");
    wr_reg(2'h0, 16'hffff);
    rd_chk(2'h0, 16'hbfbf, "ch0_unimpl");
    wr_reg(2'h1, 16'ha5a5);
    wr_reg(2'h2, 16'h5a5a);
    rd_chk(2'h1, 16'ha5a5, "scan_low_rw");
    rd_chk(2'h2, 16'h5a5a, "scan_high_rw");
    route(6'h00, 5'h02, 1'b1, adc_sel_pkg::SRC_OPAMP, 6'h02);
    route(6'h03, 5'h01, 1'b1, adc_sel_pkg::SRC_OPAMP, 6'h01);
    route(6'h06, 5'h04, 1'b1, adc_sel_pkg::SRC_OPAMP, 6'h03);
    route(6'h19, 5'h10, 1'b1, adc_sel_pkg::SRC_OPAMP, 6'h05);
    route(6'h19, 5'h0f, 1'b1, adc_sel_pkg::SRC_PIN, 6'h19);
    route(6'h00, 5'h00, 1'b1, adc_sel_pkg::SRC_PIN, 6'h00);
    route(6'h15, 5'h00, 1'b0, adc_sel_pkg::SRC_PIN, 6'h15);
    route(6'h31, 5'h00, 1'b1, adc_sel_pkg::SRC_PIN, 6'h31);
    route(6'h31, 5'h00, 1'b0, adc_sel_pkg::SRC_OPEN, 6'h00);
    route(6'h20, 5'h00, 1'b1, adc_sel_pkg::SRC_PIN, 6'h20);
    chk("second_inst_src", 16'(pos_src2), 16'(adc_sel_pkg::SRC_OPEN));
    route(6'h32, 5'h00, 1'b1, adc_sel_pkg::SRC_OPEN, 6'h00);
    route(6'h3d, 5'h00, 1'b1, adc_sel_pkg::SRC_OPEN, 6'h00);
    route(6'h3e, 5'h00, 1'b1, adc_sel_pkg::SRC_TEMP, 6'h00);
    route(6'h3f, 5'h00, 1'b1, adc_sel_pkg::SRC_OPEN, 6'h00);
    wr_reg(2'h1, 16'h0014);
    wr_reg(2'h2, 16'h0000);
    step(1'b1, 5'h02, adc_sel_pkg::SRC_PIN, 6'h02);
    step(1'b0, 5'h04, adc_sel_pkg::SRC_PIN, 6'h04);
    step(1'b0, 5'h02, adc_sel_pkg::SRC_PIN, 6'h02);
    rd_chk(2'h3, 16'h8002, "status");
    chk("scan_active", {15'h0000, scan_active}, 16'h0001);
    // status is read-only; the write must not disturb the scan position
    wr_reg(2'h3, 16'h001f);
    rd_chk(2'h3, 16'h8002, "status_ro");
    route(6'h01, 5'h07, 1'b1, adc_sel_pkg::SRC_PIN, 6'h01);
    wr_reg(2'h1, 16'h0000);
    wr_reg(2'h2, 16'h0710);
    step(1'b1, 5'h14, adc_sel_pkg::SRC_LOWREF, 6'h00);
    step(1'b0, 5'h18, adc_sel_pkg::SRC_OPAMP, 6'h01);
    step(1'b0, 5'h19, adc_sel_pkg::SRC_OPAMP, 6'h02);
    step(1'b0, 5'h1a, adc_sel_pkg::SRC_OPAMP, 6'h03);
    step(1'b0, 5'h14, adc_sel_pkg::SRC_LOWREF, 6'h00);
    route(6'h01, 5'h00, 1'b1, adc_sel_pkg::SRC_PIN, 6'h01);
    step(1'b0, 5'h18, adc_sel_pkg::SRC_PIN, 6'h03);
    step(1'b0, 5'h19, adc_sel_pkg::SRC_PIN, 6'h00);
    step(1'b0, 5'h1a, adc_sel_pkg::SRC_PIN, 6'h06);
    wr_reg(2'h2, 16'h8000);
    step(1'b1, 5'h1f, adc_sel_pkg::SRC_LOWREF, 6'h00);
    wr_reg(2'h2, 16'h0000);
    step(1'b1, 5'h00, adc_sel_pkg::SRC_PIN, 6'h00);
    rd_chk(2'h3, 16'h0000, "status_idle");
    chk("scan_idle", {15'h0000, scan_active}, 16'h0000);
    end_sim();
  end
endmodule
